// [inc/ivp_cfg.svh]
// timing-free constants, offsets and field positions for the vectored interrupt poster
`ifndef IVP_CFG_SVH
`define IVP_CFG_SVH
`define IVP_OFF_PATH_MODE     16'h2b80
`define IVP_OFF_ERR_VECTOR    16'h2b40
`define IVP_OFF_CPU_MASK      16'h2c00
`define IVP_OFF_NODE_ID       16'h2c40
`define IVP_OFF_LVL_VEC_BASE  16'h2d00
`define IVP_LVL_VEC_STRIDE    16'h0040
`define IVP_BIT_INSERT_CHAN   0
`define IVP_BIT_LOOPBACK      1
`define IVP_POST_LVL_LSB      16
`define IVP_POST_LVL_MSB      19
`define IVP_VEC_CHAN_LSB      14
`define IVP_VEC_CHAN_MSB      15
`define IVP_NODE_FIRST        4'h4
`define IVP_NODE_LAST         4'h8
`define IVP_CPU_MASK_RESET    16'h0001
`define IVP_NODE_ID_RESET     4'h4
`endif

// [inc/ivp_pkg.sv]
// types shared by both ends of the vectored interrupt link
package ivp_pkg;
	typedef logic [15:0] ivp_vec_t;
	typedef logic [1:0]  ivp_lvl_t;
	typedef logic [1:0]  ivp_chan_t;
	typedef logic [3:0]  ivp_node_t;
	typedef enum logic [1:0] {
		IVP_IDLE = 2'b00,
		IVP_POST = 2'b01
	} ivp_post_st_t;
endpackage

// [inc/ivp_link_if.sv]
// system bus link between the i/o port and a cpu module
`timescale 1ns/1ps
interface ivp_link_if (
	input wire logic mclk,
	input wire logic rstn
);
	// broadcast post write from port
	logic        post_valid;
	logic [3:0]  post_addr;
	logic [31:0] post_data;
	// csr read from cpu
	logic        rd_req;
	logic [15:0] rd_addr;
	logic        rd_ack;
	logic [31:0] rd_data;
	// write from cpu
	logic        wr_req;
	logic [15:0] wr_addr;
	logic [31:0] wr_data;
	modport port (input mclk, rstn, rd_req, rd_addr, wr_req, wr_addr, wr_data,
		output post_valid, post_addr, post_data, rd_ack, rd_data);
	modport cpu (input mclk, rstn, post_valid, post_addr, post_data, rd_ack, rd_data,
		output rd_req, rd_addr, wr_req, wr_addr, wr_data);
endinterface

// [logic/ivp_io_port.sv]
// i/o port end: per-level vector queues, broadcast post, vector reads
// Functional notes
// - loopback bit returns down packets upward
// - loopback drives fault on every channel
// - insert bit puts channel in 15:14
// - insert clear keeps adapter bits 15:14
// - only slots 4-8 post, own register
// - node id on low four address bits
// - post data names one of four levels
// - levels 0-2 hold one per channel
// - level 3 adds one port error entry
// - completed vector read services the interrupt
// - targets come from processor mask register
// - empty level reads return zero
// - queue vector first, then post
// - later reads get next pending vector
// - cpu counts outstanding per level, node
// - cpu has four-bit level enable mask
// - cpu reads vector at port node
// - targets are virtual ids, sixteen cpus
// - post bits 19:16 levels, 15:0 targets
// - level 3 error vector from register
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "ivp_cfg.svh"
module ivp_io_port import ivp_pkg::*; (
	ivp_link_if.port   bus,
	// adapter interrupt requests, one per channel
	input  wire logic        adp_irq_valid [4],
	input  wire logic [1:0]  adp_irq_level [4],
	input  wire logic [15:0] adp_irq_vector [4],
	output      logic        adp_irq_ready [4],
	// internal port error event
	input  wire logic        port_err_event,
	// channel fault outputs
	output      logic [3:0]  channel_fault_signal,
	// loopback path
	input  wire logic        down_pkt_valid,
	input  wire logic [31:0] down_pkt_data,
	output      logic        up_pkt_valid,
	output      logic [31:0] up_pkt_data
);
	logic [1:0]  path_mode_q;
	logic [15:0] err_vec_q;
	logic [15:0] cpu_mask_q;
	logic [3:0]  node_id_q;
	// pending per level per source: sources 0-3 channels, 4 port error
	logic [4:0]  pend_q [4];
	ivp_vec_t    vec_q  [4][5];
	// post requests per level per source, so every queued entry gets its own post while the node id is 4-8
	logic [4:0]  post_req_q [4];
	logic [2:0]  post_src_sel;
	logic [1:0]  post_lvl_q;
	logic [2:0]  post_src_q;
	logic        post_valid_q;
	logic [31:0] post_data_q;
	logic [3:0]  post_addr_q;
	logic        rd_ack_q;
	logic [31:0] rd_data_q;
	logic        up_valid_q;
	logic [31:0] up_data_q;
	logic        node_ok;
	logic [1:0]  rd_lvl;
	logic        rd_vec_hit;
	logic [2:0]  rd_src;
	logic        lvl_post_sel_ok;
	logic [1:0]  lvl_post_sel;

	function automatic logic [2:0] first_pend(input logic [4:0] p);
		first_pend = 3'h7;
		for (int i = 4; i >= 0; i--) begin
			if (p[i]) begin
				first_pend = 3'(i);
			end
		end
	endfunction

	function automatic ivp_vec_t build_vec(input ivp_vec_t v, input logic [1:0] ch, input logic ins);
		build_vec = v;
		if (ins) begin
			build_vec[`IVP_VEC_CHAN_MSB:`IVP_VEC_CHAN_LSB] = ch;
		end // else adapter bits pass unchanged
	endfunction

	assign node_ok = (node_id_q >= `IVP_NODE_FIRST) && (node_id_q <= `IVP_NODE_LAST);
	assign rd_vec_hit = bus.rd_req && (bus.rd_addr[15:8] == 8'(`IVP_OFF_LVL_VEC_BASE >> 8))
		&& (bus.rd_addr[5:0] == 6'h00);
	assign rd_lvl = bus.rd_addr[7:6];
	assign rd_src = first_pend(pend_q[rd_lvl]);

	// loopback forces fault on all channels, adapters stall
	assign channel_fault_signal = {4{path_mode_q[`IVP_BIT_LOOPBACK]}};
	generate
		for (genvar c = 0; c < 4; c++) begin : g_rdy
			assign adp_irq_ready[c] = !path_mode_q[`IVP_BIT_LOOPBACK] && !pend_q[adp_irq_level[c]][c];
		end
	endgenerate

	// registers
	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			path_mode_q <= 2'h0;
			err_vec_q   <= 16'h0000;
			cpu_mask_q  <= `IVP_CPU_MASK_RESET;
			node_id_q   <= `IVP_NODE_ID_RESET;
		end else if (bus.wr_req) begin
			unique case (bus.wr_addr)
				`IVP_OFF_PATH_MODE:  path_mode_q <= bus.wr_data[1:0];
				`IVP_OFF_ERR_VECTOR: err_vec_q   <= bus.wr_data[15:0];
				`IVP_OFF_CPU_MASK:   cpu_mask_q  <= bus.wr_data[15:0];
				`IVP_OFF_NODE_ID:    node_id_q   <= bus.wr_data[3:0];
				default: ;
			endcase
		end
	end

	// queues: set wins over service clear
	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			for (int l = 0; l < 4; l++) begin
				pend_q[l]     <= 5'h00;
				post_req_q[l] <= 5'h00;
				for (int s = 0; s < 5; s++) begin
					vec_q[l][s] <= 16'h0000;
				end
			end
		end else begin
			// clear of the post in flight first, so a new request in the same cycle wins
			if (post_valid_q) begin
				post_req_q[post_lvl_q][post_src_q] <= 1'b0;
			end
			if (rd_vec_hit && rd_src != 3'h7) begin
				pend_q[rd_lvl][rd_src] <= 1'b0;
			end
			for (int c = 0; c < 4; c++) begin
				if (adp_irq_valid[c] && adp_irq_ready[c]) begin
					pend_q[adp_irq_level[c]][c] <= 1'b1;
					vec_q[adp_irq_level[c]][c]  <= build_vec(adp_irq_vector[c], 2'(c),
						path_mode_q[`IVP_BIT_INSERT_CHAN]);
					post_req_q[adp_irq_level[c]][c] <= 1'b1;
				end
			end
			if (port_err_event && !pend_q[3][4]) begin
				pend_q[3][4]     <= 1'b1;
				post_req_q[3][4] <= 1'b1;
			end
		end
	end

	// at most one post every other cycle, lowest level first, after vector is queued
	always_comb begin
		lvl_post_sel_ok = 1'b0;
		lvl_post_sel    = 2'h0;
		post_src_sel    = 3'h0;
		for (int l = 3; l >= 0; l--) begin
			if (post_req_q[l] != 5'h00) begin
				lvl_post_sel_ok = 1'b1;
				lvl_post_sel    = 2'(l);
				post_src_sel    = first_pend(post_req_q[l]);
			end
		end
	end

	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			post_valid_q <= 1'b0;
			post_addr_q  <= 4'h0;
			post_data_q  <= 32'h0;
			post_lvl_q   <= 2'h0;
			post_src_q   <= 3'h0;
		end else begin
			post_valid_q <= lvl_post_sel_ok && !post_valid_q && node_ok;
			post_addr_q  <= node_id_q;
			// level enable one-hot in 19:16, targets in 15:0
			post_data_q  <= {12'h000, 4'(1 << lvl_post_sel), cpu_mask_q};
			post_lvl_q   <= lvl_post_sel;
			post_src_q   <= post_src_sel;
		end
	end
	assign bus.post_valid = post_valid_q;
	assign bus.post_addr  = post_addr_q;
	assign bus.post_data  = post_data_q;

	// read answers
	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			rd_ack_q  <= 1'b0;
			rd_data_q <= 32'h0;
		end else begin
			rd_ack_q  <= bus.rd_req;
			rd_data_q <= 32'h0;
			if (rd_vec_hit) begin
				if (rd_src == 3'h7) begin
					rd_data_q <= 32'h0;
				end else if (rd_src == 3'h4) begin
					rd_data_q <= {16'h0000, err_vec_q};
				end else begin
					rd_data_q <= {16'h0000, vec_q[rd_lvl][rd_src]};
				end
			end else if (bus.rd_req) begin
				unique case (bus.rd_addr)
					`IVP_OFF_PATH_MODE:  rd_data_q <= {30'h0, path_mode_q};
					`IVP_OFF_ERR_VECTOR: rd_data_q <= {16'h0, err_vec_q};
					`IVP_OFF_CPU_MASK:   rd_data_q <= {16'h0, cpu_mask_q};
					`IVP_OFF_NODE_ID:    rd_data_q <= {28'h0, node_id_q};
					default:             rd_data_q <= 32'h0;
				endcase
			end
		end
	end
	assign bus.rd_ack  = rd_ack_q;
	assign bus.rd_data = rd_data_q;

	// loopback: down packets return on up path
	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			up_valid_q <= 1'b0;
			up_data_q  <= 32'h0;
		end else begin
			up_valid_q <= down_pkt_valid && path_mode_q[`IVP_BIT_LOOPBACK];
			up_data_q  <= down_pkt_data;
		end
	end
	assign up_pkt_valid = up_valid_q;
	assign up_pkt_data  = up_data_q;
endmodule

// [logic/ivp_cpu.sv]
// cpu end: counts posted interrupts and reads vectors back
`timescale 1ns/1ps
`include "ivp_cfg.svh"
module ivp_cpu import ivp_pkg::*; (
	ivp_link_if.cpu    bus,
	// identity and enables
	input  wire logic [3:0]  cpu_vid,
	input  wire logic [3:0]  level_enable,
	// software command port
	input  wire logic [15:0] sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output      logic [31:0] sw_rdata,
	// status
	output      logic [3:0]  irq_level
);
	// counts per level per slot 4-8
	logic [2:0]  cnt_q [4][5];
	logic        rd_busy_q;
	logic [1:0]  rd_lvl_q;
	logic [2:0]  rd_slot_q;
	logic [31:0] sw_rdata_q;
	logic        svc;
	logic [2:0]  pslot;
	logic        post_hit [4][5];
	logic        rd_hit   [4][5];

	assign pslot = 3'(bus.post_addr - `IVP_NODE_FIRST);
	// reads of a vector register at base + level*stride, node in low nibble
	assign svc = sw_rd && (sw_addr[15:8] == 8'(`IVP_OFF_LVL_VEC_BASE >> 8));

	// per level and slot: a post taken or a vector read completed
	generate
		for (genvar l = 0; l < 4; l++) begin : g_hit_lvl
			for (genvar s = 0; s < 5; s++) begin : g_hit_slot
				assign post_hit[l][s] = bus.post_valid && pslot == 3'(s) && bus.post_data[cpu_vid]
					&& bus.post_data[`IVP_POST_LVL_LSB + l]
					&& bus.post_addr >= `IVP_NODE_FIRST && bus.post_addr <= `IVP_NODE_LAST;
				assign rd_hit[l][s] = bus.rd_ack && rd_busy_q && rd_lvl_q == 2'(l) && rd_slot_q == 3'(s);
			end
		end
	endgenerate

	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			for (int l = 0; l < 4; l++) begin
				for (int s = 0; s < 5; s++) begin
					cnt_q[l][s] <= 3'h0;
				end
			end
		end else begin
			for (int l = 0; l < 4; l++) begin
				for (int s = 0; s < 5; s++) begin
					// a post and a counted read in one cycle cancel out
					if (post_hit[l][s] && !(rd_hit[l][s] && cnt_q[l][s] != 3'h0)) begin
						if (cnt_q[l][s] < ((l == 3) ? 3'h5 : 3'h4)) begin
							cnt_q[l][s] <= cnt_q[l][s] + 3'h1;
						end
					end else if (!post_hit[l][s] && rd_hit[l][s] && cnt_q[l][s] != 3'h0) begin
						cnt_q[l][s] <= cnt_q[l][s] - 3'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			rd_busy_q <= 1'b0;
			rd_lvl_q  <= 2'h0;
			rd_slot_q <= 3'h0;
		end else begin
			rd_busy_q <= svc;
			rd_lvl_q  <= sw_addr[7:6];
			rd_slot_q <= 3'(sw_addr[3:0] - `IVP_NODE_FIRST);
		end
	end

	assign bus.rd_req  = sw_rd;
	assign bus.rd_addr = svc ? {sw_addr[15:4], 4'h0} : sw_addr;
	assign bus.wr_req  = sw_wr;
	assign bus.wr_addr = sw_addr;
	assign bus.wr_data = sw_wdata;

	always_ff @(posedge bus.mclk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			sw_rdata_q <= 32'h0;
		end else begin
			sw_rdata_q <= bus.rd_data;
		end
	end
	assign sw_rdata = bus.rd_ack ? bus.rd_data : sw_rdata_q;

	generate
		for (genvar l = 0; l < 4; l++) begin : g_lvl
			assign irq_level[l] = level_enable[l] && (cnt_q[l][0] != 3'h0 || cnt_q[l][1] != 3'h0
				|| cnt_q[l][2] != 3'h0 || cnt_q[l][3] != 3'h0 || cnt_q[l][4] != 3'h0);
		end
	endgenerate
endmodule

// [verif/ivp_link_assertions.sv]
// concurrent checks on the port-to-cpu link
`timescale 1ns/1ps
`include "ivp_cfg.svh"
module ivp_link_assertions (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        post_valid,
	input wire logic [3:0]  post_addr,
	input wire logic [31:0] post_data,
	input wire logic        rd_req,
	input wire logic [15:0] rd_addr,
	input wire logic        rd_ack,
	input wire logic [31:0] rd_data,
	input wire logic        wr_req,
	input wire logic [15:0] wr_addr,
	input wire logic [31:0] wr_data
);
	logic [15:0] mask_q;
	logic [3:0]  node_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// shadow of the target mask as written over the link
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			mask_q <= `IVP_CPU_MASK_RESET;
		else if (wr_req && wr_addr == `IVP_OFF_CPU_MASK)
			mask_q <= wr_data[15:0];
	end
	// shadow of the node id
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			node_q <= `IVP_NODE_ID_RESET;
		else if (wr_req && wr_addr == `IVP_OFF_NODE_ID)
			node_q <= wr_data[3:0];
	end
	chk_post_node_range: assert property (post_valid |-> post_addr inside {[4'h4:4'h8]})
		else $error("post from a node outside 4 to 8");
	chk_post_node_own: assert property (post_valid |-> post_addr == node_q)
		else $error("post address is not the node id");
	chk_post_target_mask: assert property (post_valid |-> post_data[15:0] == mask_q)
		else $error("post targets differ from the mask");
	chk_post_level_field: assert property (post_valid |-> $onehot(post_data[19:16]))
		else $error("post level enables not one-hot");
	chk_post_never_paired: assert property (post_valid |=> !post_valid)
		else $error("posts back to back");
	chk_read_ack_follows: assert property (rd_req |=> rd_ack)
		else $error("read not acknowledged next cycle");
	chk_ack_has_cause: assert property (rd_ack |-> $past(rd_req))
		else $error("acknowledge without a read");
	chk_unmapped_zero: assert property (rd_req && rd_addr[15:12] != 4'h2 |=> rd_data == 32'h0)
		else $error("unmapped read not zero");
	cov_post: cover property (post_valid);
	cov_passive: cover property (rd_ack && rd_data == 32'h0);
	cov_vector: cover property (rd_req ##1 rd_ack && rd_data != 32'h0);
endmodule

// [verif/io_port_vectored_interrupt_poster_tb.sv]
// self-checking bench: io port and cpu joined by the link
`timescale 1ns/1ps
`include "ivp_cfg.svh"
module io_port_vectored_interrupt_poster_tb import ivp_pkg::*;;
	logic        mclk;
	logic        rstn;
	logic        av [4];
	ivp_lvl_t    al [4];
	ivp_vec_t    avec [4];
	logic        ardy [4];
	logic        err_ev;
	logic        dn_v;
	logic        up_v;
	logic [31:0] dn_d;
	logic [31:0] up_d;
	logic [31:0] sw_wdata;
	logic [31:0] sw_rdata;
	logic [15:0] sw_addr;
	logic        sw_wr;
	logic        sw_rd;
	logic [3:0]  fault;
	logic [3:0]  irq_lvl;
	logic [3:0]  lvl_en;
	logic [3:0]  post_node;
	logic [31:0] post_d;
	int          n_errors;
	int          checks_done;
	int          n_posts;
	int          saved;
	always #20 mclk = ~mclk;
	ivp_link_if link (.mclk(mclk), .rstn(rstn));
	ivp_io_port ivp_io_port_i (.bus(link.port), .adp_irq_valid(av), .adp_irq_level(al), .adp_irq_vector(avec),
		.adp_irq_ready(ardy), .port_err_event(err_ev), .channel_fault_signal(fault), .down_pkt_valid(dn_v),
		.down_pkt_data(dn_d), .up_pkt_valid(up_v), .up_pkt_data(up_d));
	ivp_cpu ivp_cpu_i (.bus(link.cpu), .cpu_vid(4'h0), .level_enable(lvl_en), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq_level(irq_lvl));
	ivp_link_assertions ivp_link_assertions_i (.mclk(mclk), .rstn(rstn), .post_valid(link.post_valid),
		.post_addr(link.post_addr), .post_data(link.post_data), .rd_req(link.rd_req), .rd_addr(link.rd_addr),
		.rd_ack(link.rd_ack), .rd_data(link.rd_data), .wr_req(link.wr_req), .wr_addr(link.wr_addr),
		.wr_data(link.wr_data));
	// record every post seen on the link
	always @(posedge mclk) begin
		if (link.post_valid === 1'b1) begin
			n_posts <= n_posts + 1;
			post_node <= link.post_addr;
			post_d <= link.post_data;
		end
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge mclk);
		sw_rd <= 1'b0;
		@(negedge mclk);
		chk(sw_rdata, exp);
		@(posedge mclk);
	endtask
	// vector read at this port's node, node 4
	task automatic rv(input ivp_lvl_t l, input ivp_vec_t exp);
		rd(`IVP_OFF_LVL_VEC_BASE + 16'(l) * `IVP_LVL_VEC_STRIDE + 16'h4, {16'h0, exp});
	endtask
	// bit 4 of chs raises the port error event
	task automatic raise(input logic [4:0] chs, input ivp_lvl_t l, input ivp_vec_t v, input int posts);
		int n;
		n = n_posts + posts;
		err_ev <= chs[4];
		for (int c = 0; c < 4; c++) begin
			av[c] <= chs[c];
			al[c] <= l;
			avec[c] <= v;
		end
		@(negedge mclk);
		for (int c = 0; c < 4; c++)
			if (chs[c])
				chk(ardy[c], 1'b1);
		@(posedge mclk);
		err_ev <= 1'b0;
		for (int c = 0; c < 4; c++)
			av[c] <= 1'b0;
		for (int k = 0; k < 60 && n_posts < n; k++)
			@(posedge mclk);
		chk(n_posts >= n, 1'b1);
		@(posedge mclk);
	endtask
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		{err_ev, dn_v, sw_wr, sw_rd, dn_d, sw_wdata, sw_addr} = '0;
		{n_errors, checks_done, n_posts} = '0;
		lvl_en = 4'hf;
		for (int c = 0; c < 4; c++) begin
			av[c] = 1'b0;
			al[c] = 2'd0;
			avec[c] = 16'h0;
		end
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(`IVP_OFF_PATH_MODE, 32'h0);
		rd(`IVP_OFF_CPU_MASK, 32'h1);
		rd(16'h3f00, 32'h0);
		raise(5'h04, 2'd1, 16'hc123, 1);
		chk(irq_lvl, 4'h2);
		chk(post_d, 32'h0002_0001);
		lvl_en <= 4'hd;
		@(negedge mclk);
		chk(irq_lvl, 4'h0);
		@(posedge mclk);
		lvl_en <= 4'hf;
		rv(2'd1, 16'hc123);
		rv(2'd1, 16'h0);
		chk(irq_lvl, 4'h0);
		wr(`IVP_OFF_PATH_MODE, 32'h1);
		rd(`IVP_OFF_PATH_MODE, 32'h1);
		raise(5'h0f, 2'd0, 16'h0055, 4);
		for (int c = 0; c < 4; c++)
			rv(2'd0, {2'(c), 14'h0055});
		rv(2'd0, 16'h0);
		wr(`IVP_OFF_ERR_VECTOR, 32'h7e01);
		raise(5'h18, 2'd3, 16'h0abc, 2);
		chk(irq_lvl, 4'h8);
		rv(2'd3, 16'hcabc);
		rv(2'd3, 16'h7e01);
		rv(2'd3, 16'h0);
		wr(`IVP_OFF_PATH_MODE, 32'h2);
		chk(fault, 4'hf);
		chk(ardy[0], 1'b0);
		dn_d <= 32'h5a5a_0001;
		dn_v <= 1'b1;
		@(posedge mclk);
		dn_v <= 1'b0;
		@(negedge mclk);
		chk(up_v, 1'b1);
		chk(up_d, 32'h5a5a_0001);
		@(posedge mclk);
		wr(`IVP_OFF_PATH_MODE, 32'h0);
		chk(fault, 4'h0);
		wr(`IVP_OFF_CPU_MASK, 32'h0003);
		wr(`IVP_OFF_NODE_ID, 32'h6);
		raise(5'h01, 2'd2, 16'h0123, 1);
		chk(post_node, 4'h6);
		chk(post_d, 32'h0004_0003);
		chk(irq_lvl, 4'h4);
		wr(`IVP_OFF_NODE_ID, 32'h9);
		saved = n_posts;
		raise(5'h02, 2'd2, 16'h0124, 0);
		repeat (6) @(posedge mclk);
		chk(n_posts, saved);
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		end_of_test();
	end
endmodule
